// File: hw/adc_th_pkg.sv
// Register map, field positions, reset values and types of the track-and-hold sequencer.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
package adc_th_pkg;
  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_POS = 10'h0bb;
  localparam logic [9:0] IDX_CTRL = 10'h0c0;
  localparam logic [9:0] IDX_CFG = 10'h0c1;
  localparam logic [9:0] IDX_RES = 10'h0c2;
  localparam logic [9:0] IDX_ISTS = 10'h0c3;
  localparam logic [9:0] IDX_IEN = 10'h0c4;
  localparam logic [9:0] IDX_ICLR = 10'h0c5;
  // ==========================================================================
  // Field positions
  localparam int unsigned CTL_EN = 7;
  localparam int unsigned CTL_TM = 6;
  localparam int unsigned CTL_DONE = 5;
  localparam int unsigned CTL_BUSY = 4;
  localparam int unsigned CTL_SRC = 0;
  localparam int unsigned CFG_DIV_LSB = 3;
  localparam int unsigned POS_W = 5;
  localparam int unsigned RES_BITS = 10;
  // ==========================================================================
  // Reset values and codes
  localparam logic [4:0] DIV_RST = 5'h1f;
  localparam logic [4:0] POS_RST = 5'h00;
  localparam logic [4:0] POS_LAST_PIN = 5'h10;
  localparam logic [4:0] POS_SUPPLY = 5'h1f;
  localparam logic [1:0] TRACK_LAST = 2'h2;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Types
  typedef enum {st_idle, st_lptrack, st_conv} state_t;
  typedef struct packed {
    logic en;
    logic lp;
    logic pin_src;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '{en: 1'b0, lp: 1'b0, pin_src: 1'b0};

  // Index lies in the implemented map
  function automatic logic is_mapped(input logic [9:0] idx);
    return idx == IDX_POS || (idx >= IDX_CTRL && idx <= IDX_ICLR);
  endfunction

  // Selector code names a port pin or the supply
  function automatic logic code_ok(input logic [4:0] c);
    return c <= POS_LAST_PIN || c == POS_SUPPLY;
  endfunction
endpackage

// File: hw/adc_track_hold.sv
// Track-and-hold sequencer, divider, SAR step logic, input selector and AXI4-Lite registers.
// Assumes a synchronous start pin, standby level and comparator input from the analog side.
//
// Summary of operation
// R1 - Default mode tracks except during conversion
// R2 - Tracking-mode bit one selects low-power tracking
// R3 - Low-power: three converter clocks tracking before converting
// R4 - Pin start: track while low, convert on rise
// R5 - Standby shuts tracking off
// R6 - Software waits minimum tracking time after mux change
// R7 - Software prefers low-power mode when switching often
// R8 - Each conversion yields ten result bits
// R9 - Five-bit code selects pins, supply; rest reserved
// R10 - Selector upper three bits read zero, ignore writes
// R11 - Converter clock is system clock over divider+1
// R12 - Busy falls: set done flag, request interrupt
`timescale 1ns/1ps
module adc_track_hold
  import adc_th_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write channels
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog side and triggers
  input wire logic external_convert_start,
  input wire logic standby_in,
  input wire logic cmp_hi,
  output logic track_r,
  output logic [4:0] positive_input_code,
  output logic [9:0] sar_trial,
  output logic irq_r
);
  // ==========================================================================
  // Register state
  ctrl_t ctrl_r;
  logic [4:0] div_r, pos_r, div_cnt_r;
  logic done_r, ists_r, ien_r, pin_prev_r;
  logic [9:0] trial_r, result_r;
  logic [3:0] bit_r;
  logic [1:0] trk_cnt_r;
  state_t state_r;
  logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [9:0] aw_idx_r;
  logic [31:0] wdata_h_r, rdata_r;
  logic [3:0] wstrb_h_r;
  logic [1:0] bresp_r, rresp_r;

  logic do_wr, wr_en, tick, sw_start, pin_rise, start, conv_end, busy;
  logic [31:0] rd_val;

  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign wr_en = do_wr && is_mapped(aw_idx_r) && wstrb_h_r[0];
  assign busy = state_r != st_idle;
  assign tick = div_cnt_r == div_r; // [R11]
  assign sw_start = wr_en && aw_idx_r == IDX_CTRL && wdata_h_r[CTL_BUSY] && !ctrl_r.pin_src;
  assign pin_rise = external_convert_start && !pin_prev_r && ctrl_r.pin_src; // [R4]
  assign start = (sw_start || pin_rise) && ctrl_r.en && !standby_in && state_r == st_idle;
  assign conv_end = state_r == st_conv && tick && bit_r == 4'h0;

  // ==========================================================================
  // AXI write address and data holding
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_have_r <= 1'b0;
      awready_r <= 1'b1;
      aw_idx_r <= 10'h000;
      w_have_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_h_r <= 32'h0;
      wstrb_h_r <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        aw_idx_r <= awaddr[11:2];
      end else if (do_wr) begin
        aw_have_r <= 1'b0;
        awready_r <= 1'b1;
      end
      if (wvalid && wready_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_h_r <= wdata;
        wstrb_h_r <= wstrb;
      end else if (do_wr) begin
        w_have_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // Write response after both halves are in
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    rd_val = 32'h0;
    case (araddr[11:2])
      IDX_POS: rd_val[4:0] = pos_r; // [R10]
      IDX_CTRL: begin
        rd_val[CTL_EN] = ctrl_r.en;
        rd_val[CTL_TM] = ctrl_r.lp;
        rd_val[CTL_DONE] = done_r;
        rd_val[CTL_BUSY] = busy;
        rd_val[CTL_SRC] = ctrl_r.pin_src;
      end
      IDX_CFG: rd_val[7:3] = div_r;
      IDX_RES: rd_val[9:0] = result_r;
      IDX_ISTS: rd_val[0] = ists_r;
      IDX_IEN: rd_val[0] = ien_r;
      default: rd_val = 32'h0;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= is_mapped(araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Software-written configuration
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      div_r <= DIV_RST;
      pos_r <= POS_RST;
      ien_r <= 1'b0;
    end else if (wr_en) begin
      if (aw_idx_r == IDX_CTRL) begin
        ctrl_r.en <= wdata_h_r[CTL_EN];
        ctrl_r.lp <= wdata_h_r[CTL_TM]; // [R2]
        ctrl_r.pin_src <= wdata_h_r[CTL_SRC];
      end
      if (aw_idx_r == IDX_CFG)
        div_r <= wdata_h_r[7:3];
      if (aw_idx_r == IDX_POS)
        pos_r <= wdata_h_r[4:0]; // [R9] [R10]
      if (aw_idx_r == IDX_IEN)
        ien_r <= wdata_h_r[0];
    end
  end

  // Done flag and interrupt status; a completion beats a clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_r <= 1'b0;
      ists_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (conv_end)
        done_r <= 1'b1; // [R12]
      else if (wr_en && aw_idx_r == IDX_CTRL && !wdata_h_r[CTL_DONE])
        done_r <= 1'b0;
      if (conv_end)
        ists_r <= 1'b1; // [R12]
      else if (wr_en && aw_idx_r == IDX_ICLR && wdata_h_r[0])
        ists_r <= 1'b0;
      irq_r <= ists_r && ien_r; // [R12]
    end
  end

  // ==========================================================================
  // Converter clock divider, restarted at each start
  always_ff @(posedge clk) begin
    if (!rst_b)
      div_cnt_r <= 5'h00;
    else if (start || tick)
      div_cnt_r <= 5'h00; // [R11]
    else
      div_cnt_r <= div_cnt_r + 5'h01;
  end

  // Sequencer: idle, low-power tracking, successive approximation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= st_idle;
      trk_cnt_r <= 2'h0;
      bit_r <= 4'h0;
      trial_r <= 10'h000;
      result_r <= 10'h000;
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= external_convert_start;
      case (state_r)
        st_idle: begin
          if (start) begin
            trk_cnt_r <= 2'h0;
            bit_r <= SAR_TOP_BIT;
            trial_r <= SAR_FIRST;
            if (sw_start && wdata_h_r[CTL_TM]) // Mode written with the start applies
              state_r <= st_lptrack; // [R3]
            else
              state_r <= st_conv; // [R4]
          end
        end
        st_lptrack: begin
          if (tick) begin
            trk_cnt_r <= trk_cnt_r + 2'h1;
            if (trk_cnt_r == TRACK_LAST)
              state_r <= st_conv; // [R3]
          end
        end
        st_conv: begin
          if (tick) begin
            if (!cmp_hi)
              trial_r[bit_r] <= 1'b0; // [R8]
            if (bit_r == 4'h0) begin
              result_r <= cmp_hi ? trial_r : (trial_r & ~10'h001);
              state_r <= st_idle;
            end else begin
              trial_r[bit_r - 4'h1] <= 1'b1;
              bit_r <= bit_r - 4'h1;
            end
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Track switch drive; off for disable, standby, reserved code or conversion
  always_ff @(posedge clk) begin
    if (!rst_b)
      track_r <= 1'b0;
    else if (!ctrl_r.en || standby_in || !code_ok(pos_r)) // [R5] [R9]
      track_r <= 1'b0;
    else if (state_r == st_conv)
      track_r <= 1'b0; // [R1]
    else if (state_r == st_lptrack)
      track_r <= 1'b1; // [R3]
    else if (ctrl_r.lp)
      track_r <= ctrl_r.pin_src && !external_convert_start; // [R2] [R4]
    else
      track_r <= 1'b1; // [R1]
  end

  // ==========================================================================
  // Checks
  logic [7:0] lpt_cyc_r;
  logic [3:0] conv_ticks_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lpt_cyc_r <= 8'h00;
      conv_ticks_r <= 4'h0;
    end else begin
      lpt_cyc_r <= (state_r == st_lptrack) ? lpt_cyc_r + 8'h01 : 8'h00;
      conv_ticks_r <= (state_r != st_conv) ? 4'h0 : conv_ticks_r + {3'h0, tick};
    end
  end

  default_track_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    state_r == st_idle && ctrl_r.en && !ctrl_r.lp && !standby_in && code_ok(pos_r)
    |=> track_r) else $error("continuous tracking lost");
  conv_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    state_r == st_conv |=> !track_r) else $error("tracking during conversion");
  lp_idle_a: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    state_r == st_idle && ctrl_r.lp && !ctrl_r.pin_src |=> !track_r)
    else $error("low-power mode tracks while idle");
  lp_track_len_a: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R11]
    state_r == st_lptrack && tick && trk_cnt_r == TRACK_LAST
    |-> int'(lpt_cyc_r) == 3 * (int'(div_r) + 1) - 1)
    else $error("low-power tracking interval wrong");
  pin_start_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    start && ctrl_r.lp && ctrl_r.pin_src |=> state_r == st_conv ##1 !track_r)
    else $error("pin rise did not start conversion");
  pin_low_track_a: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    state_r == st_idle && ctrl_r.en && ctrl_r.lp && ctrl_r.pin_src && !standby_in
    && code_ok(pos_r) |=> track_r == !$past(external_convert_start))
    else $error("pin-low tracking wrong");
  standby_off_a: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    standby_in |=> !track_r) else $error("tracking in standby");
  ten_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    conv_end |-> conv_ticks_r == 4'h9 ##1 state_r == st_idle)
    else $error("conversion not ten steps");
  reserved_code_a: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    wr_en && aw_idx_r == IDX_POS && wdata_h_r[4:0] == 5'h11 |=> ##1 !track_r)
    else $error("reserved code tracks");
  sel_upper_a: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
    arvalid && arready_r && araddr[11:2] == IDX_POS |=> rdata_r[31:5] == 27'h0)
    else $error("selector upper bits not zero");
  done_irq_a: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    state_r == st_conv && conv_end |=> done_r && ists_r && !busy ##1 irq_r == ien_r)
    else $error("completion not flagged");

  // ==========================================================================
  // Outputs
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign positive_input_code = pos_r;
  assign sar_trial = trial_r;
endmodule // adc_track_hold

// File: sim/analog_side.sv
// Comparator stand-in for the analog front end of the sequencer.
// Assumes sar_trial is the trial code and level is the input held by the bench.
`timescale 1ns/1ps
module analog_side (
  // Trial code from the sequencer
  input wire logic [9:0] sar_trial,
  // Input level chosen by the bench
  input wire logic [9:0] level,
  // Comparator decision
  output logic cmp_hi
);
  // ==========================================================================
  // Comparator
  // Input at or above the trial keeps that bit, so a full search lands on level
  assign cmp_hi = level >= sar_trial;
endmodule // analog_side

// File: sim/testbench.sv
// Self-checking bench for the track-and-hold sequencer and its registers.
// Assumes the comparator stand-in analog_side and a 20 MHz clock.
`timescale 1ns/1ps
module testbench;
  import adc_th_pkg::*;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd, seed = 32'h0001033e;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, track_r, irq_r, cmp_hi;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  logic pin = 1'b0, standby = 1'b0;
  logic [4:0] code;
  logic [9:0] sar_trial, level = 10'h000;
  int num_errors = 0, checked = 0, cnt, trk;
  int exp_q[$];
  int divs[6] = '{0, 1, 3, 0, 2, 31};
  logic lps[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  // Clock
  always #25 clk = ~clk;

  // ==========================================================================
  // Design and far side
  adc_track_hold u_dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .external_convert_start(pin), .standby_in(standby),
    .cmp_hi(cmp_hi), .track_r(track_r), .positive_input_code(code), .sar_trial(sar_trial),
    .irq_r(irq_r));
  analog_side u_far (.sar_trial(sar_trial), .level(level), .cmp_hi(cmp_hi));

  // ==========================================================================
  // Helpers
  // Step of the stimulus generator
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write one word; the extra edge first keeps two transfers from touching in one step
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  // Read one word
  task automatic rdw(input logic [9:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  // Read and compare
  task automatic rc(input string nm, input logic [9:0] idx, input logic [31:0] e);
    rdw(idx);
    chk(nm, e, rd);
  endtask

  // One software conversion, timed from the write response to the interrupt
  task automatic conv(input int d, input logic lp);
    wr(IDX_CFG, 32'(d << CFG_DIV_LSB));
    seed = lfsr(seed);
    level <= seed[9:0];
    exp_q.push_back(int'(seed[9:0]));
    // Mode first, so idle tracking before the start already follows it
    wr(IDX_CTRL, 32'h80 | (32'(lp) << CTL_TM));
    wr(IDX_CTRL, 32'h90 | (32'(lp) << CTL_TM));
    cnt = 0;
    trk = 0;
    while (irq_r !== 1'b1) begin
      trk += int'(track_r === 1'b1);
      @(posedge clk);
      cnt++;
    end
    // Start lands one edge before the response; the interrupt flop adds one more
    chk("conv_cycles", (lp ? 13 : 10) * (d + 1) + 1, cnt);
    chk("track_cycles", lp ? 3 * (d + 1) : 1, trk);
    rc("ctrl_done", IDX_CTRL, 32'ha0 | (32'(lp) << CTL_TM));
    rc("result", IDX_RES, exp_q.pop_front());
    wr(IDX_ICLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clear", 1'b0, irq_r);
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, well beyond the fewer than two thousand cycles the sequence needs
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    final_report;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rc("pos_rst", IDX_POS, 32'h0);
    rc("cfg_rst", IDX_CFG, 32'hf8);
    rc("ctrl_rst", IDX_CTRL, 32'h0);
    rdw(10'h0c6);
    chk("unmapped_rresp", RESP_SLVERR, rs);
    wr(10'h0c6, 32'hff);
    chk("unmapped_bresp", RESP_SLVERR, rs);
    wr(IDX_POS, 32'h3, 4'h0);
    rc("strobe_off", IDX_POS, 32'h0);
    // Every selector code, with random upper bits that must be dropped
    wr(IDX_CTRL, 32'h80);
    for (int c = 0; c < 32; c++) begin
      seed = lfsr(seed);
      wr(IDX_POS, {seed[31:5], 5'(c)});
      rc("pos_code", IDX_POS, 32'(c));
      repeat (2) @(posedge clk);
      chk("code_pin", 32'(c), {27'h0, code});
      chk("code_track", 32'(c <= 16 || c == 31), {31'h0, track_r});
    end
    // Conversions over divider settings and both tracking modes
    wr(IDX_IEN, 32'h1);
    foreach (divs[i]) conv(divs[i], lps[i]);
    // Masked interrupt, busy flag, then unmask and clear
    wr(IDX_IEN, 32'h0);
    wr(IDX_CFG, 32'hf8);
    wr(IDX_CTRL, 32'h90);
    rc("busy_set", IDX_CTRL, 32'h90);
    repeat (340) @(posedge clk);
    rc("busy_clear", IDX_CTRL, 32'ha0);
    rc("status_set", IDX_ISTS, 32'h1);
    chk("irq_masked", 1'b0, irq_r);
    wr(IDX_IEN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_unmasked", 1'b1, irq_r);
    wr(IDX_ICLR, 32'h1);
    rc("status_clear", IDX_ISTS, 32'h0);
    rc("iclr_read", IDX_ICLR, 32'h0);
    // Standby shuts tracking and blocks a start
    wr(IDX_CFG, 32'h0);
    standby <= 1'b1;
    wr(IDX_CTRL, 32'h90);
    repeat (30) @(posedge clk);
    chk("standby_track", 1'b0, track_r);
    rc("standby_block", IDX_CTRL, 32'h80);
    standby <= 1'b0;
    repeat (3) @(posedge clk);
    chk("idle_track", 1'b1, track_r);
    // Pin start in low-power mode after a selector change
    wr(IDX_POS, 32'h5);
    wr(IDX_CTRL, 32'hc1);
    seed = lfsr(seed);
    level <= seed[9:0];
    exp_q.push_back(int'(seed[9:0]));
    repeat (8) @(posedge clk);
    chk("pin_low_track", 1'b1, track_r);
    chk("pin_low_idle", 1'b0, irq_r);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin_rise_hold", 1'b0, track_r);
    while (irq_r !== 1'b1) @(posedge clk);
    rc("pin_result", IDX_RES, exp_q.pop_front());
    final_report;
  end
endmodule // testbench
